// >>> dv/rrc_asserts.sv
// Purpose: Port-level assertions for the rate/route control registers.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Detector timing assumes a two-stage synchroniser.
`timescale 1ns/1ps
module rrc_checker
   import rrc_pkg::*;
(
   input wire logic              core_clk_i,         // Clock
   input wire logic              nrst_i,             // Reset, active low
   input wire logic              wr_i,               // Write strobe
   input wire logic              rd_i,               // Read strobe
   input wire logic [ADDR_W-1:0] addr_i,             // Offset
   input wire logic [DATA_W-1:0] rdata_o,            // Read data
   input wire logic              rvalid_o,           // Read valid
   input wire logic              pri_detect_i,       // Primary detector
   input wire logic              cdr_reset_o,        // Loop reset
   input wire logic              rate_3g_en_o,       // 3G allowed
   input wire logic              mux_sel_sec_o,      // Mux on secondary
   input wire logic              first_output_en_o,  // First driver on
   input wire logic              second_output_en_o, // Second driver on
   input wire logic              core_pwrdn_o,       // Core off
   input wire logic              cdr_pwrdn_o         // Loop off
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   logic armed_q;

   // Past values are unknown until one clean edge after reset
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
      end
   end

   // Four edges: two synchroniser stages plus the reset-held first sample
   sequence s_pri_gone; (!pri_detect_i && !mux_sel_sec_o) [*4]; endsequence
   sequence s_pri_here; (pri_detect_i && !mux_sel_sec_o) [*4]; endsequence
   property p_pwr_off; s_pri_gone |-> core_pwrdn_o && cdr_pwrdn_o; endproperty
   property p_pwr_on; s_pri_here |-> !core_pwrdn_o && !cdr_pwrdn_o; endproperty
   property p_drv_off; core_pwrdn_o |-> !first_output_en_o && !second_output_en_o; endproperty
   property p_pri_route; !mux_sel_sec_o && !core_pwrdn_o |-> first_output_en_o; endproperty
   property p_sec_route; mux_sel_sec_o && !core_pwrdn_o |-> second_output_en_o; endproperty
   property p_cdr_src;
      armed_q && $changed(cdr_reset_o) |-> $past(wr_i) && $past(addr_i) == OFS_CDR_RESET;
   endproperty
   property p_rate_src;
      armed_q && $changed(rate_3g_en_o) |-> $past(wr_i) && $past(addr_i) == OFS_RATE_MASK;
   endproperty
   property p_mux_src;
      armed_q && $changed(mux_sel_sec_o) |-> $past(wr_i) && $past(addr_i) == OFS_ROUTE_SEL;
   endproperty
   property p_rd_ans; rd_i |=> rvalid_o; endproperty
   property p_rd_hold; armed_q && !rvalid_o |-> $stable(rdata_o); endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("no power down");
   a_pwr_on: assert property (p_pwr_on) else $error("power down with signal");
   a_drv_off: assert property (p_drv_off) else $error("driver on in power down");
   a_pri_route: assert property (p_pri_route) else $error("first driver off");
   a_sec_route: assert property (p_sec_route) else $error("second driver off");
   a_cdr_src: assert property (p_cdr_src) else $error("loop reset moved alone");
   a_rate_src: assert property (p_rate_src) else $error("rate enable moved alone");
   a_mux_src: assert property (p_mux_src) else $error("mux moved alone");
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // rrc_checker

bind reclocker_rate_route_control rrc_checker rrc_checker_inst (.core_clk_i(core_clk_i),
   .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .pri_detect_i(pri_detect_i), .cdr_reset_o(cdr_reset_o),
   .rate_3g_en_o(rate_3g_en_o), .mux_sel_sec_o(mux_sel_sec_o),
   .first_output_en_o(first_output_en_o), .second_output_en_o(second_output_en_o),
   .core_pwrdn_o(core_pwrdn_o), .cdr_pwrdn_o(cdr_pwrdn_o));

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the rate/route control registers.
// Assumes: Strobes are one-cycle pulses; detectors settle in two edges.
// Notes:   Channel bank stays selected after the first refused read.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench
   import rrc_pkg::*;
;
   logic       core_clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic       pri_detect_i = 1'b0;
   logic       sec_detect_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] wmask_i = 8'h00;
   logic [7:0] rdata_o;
   logic       rvalid_o, cdr_reset_o, rate_270m_en_o, rate_1g5_en_o, rate_3g_en_o;
   logic       mux_sel_sec_o, first_output_en_o, second_output_en_o, core_pwrdn_o, cdr_pwrdn_o;
   logic [3:0] route_tbl [4] = '{4'b0110, 4'b0100, 4'b1010, 4'b1110};
   int         bad_count = 0;
   int         num_checks = 0;
   int         cycles = 0;
   logic [2:0] rates_view;
   logic [3:0] pwr_view;
   logic [3:0] route_view;

   assign rates_view = {rate_270m_en_o, rate_1g5_en_o, rate_3g_en_o};
   assign pwr_view   = {core_pwrdn_o, cdr_pwrdn_o, first_output_en_o, second_output_en_o};
   assign route_view = {mux_sel_sec_o, first_output_en_o, second_output_en_o, core_pwrdn_o};

   always #5 core_clk_i = ~core_clk_i;

   reclocker_rate_route_control reclocker_rate_route_control_inst (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wmask_i(wmask_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .pri_detect_i(pri_detect_i), .sec_detect_i(sec_detect_i), .cdr_reset_o(cdr_reset_o),
      .rate_270m_en_o(rate_270m_en_o), .rate_1g5_en_o(rate_1g5_en_o),
      .rate_3g_en_o(rate_3g_en_o), .mux_sel_sec_o(mux_sel_sec_o),
      .first_output_en_o(first_output_en_o), .second_output_en_o(second_output_en_o),
      .core_pwrdn_o(core_pwrdn_o), .cdr_pwrdn_o(cdr_pwrdn_o));

   // ---------------------------------------------------------------
   // Register access
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      wmask_i <= m;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      `CHK(rvalid_o, 1'b1)
      `CHK(rdata_o, e)
   endtask

   // Two synchroniser edges plus margin before looking
   task automatic detect(input logic p, input logic s);
      @(posedge core_clk_i);
      pri_detect_i <= p;
      sec_detect_i <= s;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1;
      `CHK(rates_view, 3'b111)
      `CHK(pwr_view, 4'b1100)
      rd(OFS_RATE_MASK, 8'h00);
      wr(OFS_BANK_SEL, BANK_CHANNEL, BANK_FIELD_MASK);
      rd(OFS_RATE_MASK, 8'h1c);
      wr(OFS_RATE_MASK, 8'he3, 8'h00);
      rd(OFS_RATE_MASK, 8'h1c);
      for (int i = 2; i <= 4; i++) begin
         wr(OFS_RATE_MASK, 8'h00, 8'(8'h01 << i));
         `CHK(rates_view, 3'(7 ^ (1 << (i - 2))))
         wr(OFS_RATE_MASK, 8'hff, 8'(8'h01 << i));
      end
      wr(OFS_RATE_MASK, 8'hff, 8'hc0);
      rd(OFS_RATE_MASK, 8'hdc);
      wr(OFS_CDR_RESET, 8'h0c, 8'h0c);
      `CHK(cdr_reset_o, 1'b1)
      rd(OFS_CDR_RESET, 8'h0c);
      wr(OFS_CDR_RESET, 8'h00, 8'h0c);
      `CHK(cdr_reset_o, 1'b0)
      detect(1'b1, 1'b0);
      `CHK(pwr_view, 4'b0011)
      rd(OFS_SIG_ABSENT, 8'h02);
      wr(OFS_SIG_ABSENT, 8'hff, 8'hff);
      rd(OFS_SIG_ABSENT, 8'h02);
      detect(1'b0, 1'b1);
      rd(OFS_SIG_ABSENT, 8'h01);
      `CHK(pwr_view, 4'b1100)
      detect(1'b1, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_ROUTE_SEL, 8'(c), ROUTE_FIELD_MSK);
         `CHK(route_view, route_tbl[c])
      end
      rd(OFS_ROUTE_SEL, 8'h03);
      detect(1'b1, 1'b0);
      `CHK(pwr_view, 4'b1100)
      report_and_stop();
   end
endmodule // testbench

// >>> hw/masked_reg.sv
// Purpose: One 8-bit register updated under a write mask.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Only bits set in the mask take the new data.
`timescale 1ns/1ps
module masked_reg #(
   parameter int          W       = 8,
   parameter logic [7:0]  RST_VAL = 8'h00
) (
   input  wire logic          core_clk_i, // Register clock
   input  wire logic          nrst_i,     // Async reset, active low
   input  wire logic          we_i,       // Write strobe for this register
   input  wire logic [W-1:0]  wdata_i,    // Write data
   input  wire logic [W-1:0]  wmask_i,    // Write mask
   output logic      [W-1:0]  q_o         // Stored value
);

   logic [W-1:0] q_d;

   // Masked update keeps unmasked bits
   assign q_d = (q_o & ~wmask_i) | (wdata_i & wmask_i);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_o <= RST_VAL[W-1:0];
      end else if (we_i) begin
         q_o <= q_d;
      end
   end

endmodule // masked_reg

// >>> hw/reclocker_rate_route_control.sv
// Purpose: Channel control registers of a serial video reclocker: rate mask,
//          recovery-loop reset, input signal status and input/output routing.
// Assumes: Host issues masked register writes and reads on core_clk_i;
//          signal detector levels arrive asynchronously from the analog front.
// Notes:   Channel registers answer only while the channel bank is selected.
//          Reserved bits of the writable registers are plain storage.
//          Loss of signal on the selected input overrides the routing enables.
`timescale 1ns/1ps

module reclocker_rate_route_control
   import rrc_pkg::*;
(
   input  wire logic               core_clk_i,        // 100 MHz register clock
   input  wire logic               nrst_i,            // Async reset, active low
   input  wire logic               wr_i,              // Register write strobe
   input  wire logic               rd_i,              // Register read strobe
   input  wire logic [ADDR_W-1:0]  addr_i,            // Register offset
   input  wire logic [DATA_W-1:0]  wdata_i,           // Write data
   input  wire logic [DATA_W-1:0]  wmask_i,           // Write mask
   output logic      [DATA_W-1:0]  rdata_o,           // Read data, registered
   output logic                    rvalid_o,          // Read data valid pulse
   input  wire logic               pri_detect_i,      // Primary input detector, async
   input  wire logic               sec_detect_i,      // Secondary input detector, async
   output logic                    cdr_reset_o,       // Recovery loop reset
   output logic                    rate_270m_en_o,    // Divider choice 270 Mb/s allowed
   output logic                    rate_1g5_en_o,     // Divider choice 1.5 Gb/s allowed
   output logic                    rate_3g_en_o,      // Divider choice 3 Gb/s allowed
   output logic                    mux_sel_sec_o,     // Input mux picks secondary input
   output logic                    first_output_en_o, // First output driver on
   output logic                    second_output_en_o,// Second output driver on
   output logic                    core_pwrdn_o,      // Core power down
   output logic                    cdr_pwrdn_o        // Recovery loop power down
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic [7:0] bank_q;
   logic [7:0] rate_mask_q;
   logic [7:0] cdr_ctl_q;
   logic [7:0] route_q;
   logic       chan_bank;
   logic       we_bank;
   logic       we_rate;
   logic       we_cdr;
   logic       we_route;
   logic       hit_bank;
   logic       hit_absent;
   logic       hit_cdr;
   logic       hit_route;
   logic       hit_rate;

   // Offset match, shared by the write strobes and the read mux
   function automatic logic offset_hit(input logic [ADDR_W-1:0] a,
                                       input logic [7:0]        ofs);
      offset_hit = (a == ofs);
   endfunction

   // Channel registers answer only while the channel bank is selected
   function automatic logic bank_is_channel(input logic [7:0] sel);
      bank_is_channel = ((sel & BANK_FIELD_MASK) == BANK_CHANNEL);
   endfunction

   assign hit_bank   = offset_hit(addr_i, OFS_BANK_SEL);
   assign hit_absent = chan_bank && offset_hit(addr_i, OFS_SIG_ABSENT);
   assign hit_cdr    = chan_bank && offset_hit(addr_i, OFS_CDR_RESET);
   assign hit_route  = chan_bank && offset_hit(addr_i, OFS_ROUTE_SEL);
   assign hit_rate   = chan_bank && offset_hit(addr_i, OFS_RATE_MASK);

   // Bank register is always reachable; channel registers only in bank 4
   assign chan_bank = bank_is_channel(bank_q);
   assign we_bank   = wr_i && hit_bank;
   assign we_rate   = wr_i && hit_rate;
   assign we_cdr    = wr_i && hit_cdr;
   assign we_route  = wr_i && hit_route;
   // Status word has no strobe: writes to it are dropped here

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   masked_reg #(.W(8), .RST_VAL(BANK_SEL_RST)) u_bank (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .we_i       (we_bank),
      .wdata_i    (wdata_i),
      .wmask_i    (wmask_i),
      .q_o        (bank_q)
   );

   // All rates permitted out of reset
   masked_reg #(.W(8), .RST_VAL(RATE_MASK_RST)) u_rate (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .we_i       (we_rate),
      .wdata_i    (wdata_i),
      .wmask_i    (wmask_i),
      .q_o        (rate_mask_q)
   );

   masked_reg #(.W(8), .RST_VAL(CDR_RESET_RST)) u_cdr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .we_i       (we_cdr),
      .wdata_i    (wdata_i),
      .wmask_i    (wmask_i),
      .q_o        (cdr_ctl_q)
   );

   masked_reg #(.W(8), .RST_VAL(ROUTE_SEL_RST)) u_route (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .we_i       (we_route),
      .wdata_i    (wdata_i),
      .wmask_i    (wmask_i),
      .q_o        (route_q)
   );

   // ------------------------------------------------------------
   // Signal detector synchronisers
   // ------------------------------------------------------------
   logic pri_meta_q;
   logic pri_sync_q;
   logic sec_meta_q;
   logic sec_sync_q;

   // Primary chain; reset reads as absent, so outputs start powered down
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pri_meta_q <= 1'b0;
         pri_sync_q <= 1'b0;
      end else begin
         pri_meta_q <= pri_detect_i;
         pri_sync_q <= pri_meta_q;
      end
   end

   // Secondary chain, kept apart so one input never masks the other
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sec_meta_q <= 1'b0;
         sec_sync_q <= 1'b0;
      end else begin
         sec_meta_q <= sec_detect_i;
         sec_sync_q <= sec_meta_q;
      end
   end

   logic [7:0] absent_status;

   // Read-only view: no write path exists into this word
   assign absent_status = {6'h00, ~sec_sync_q, ~pri_sync_q};

   // ------------------------------------------------------------
   // Rate mask and recovery loop reset
   // ------------------------------------------------------------
   logic cdr_reset_d;

   // One mask bit per rate family; a cleared bit drops that divider choice
   function automatic logic rate_permitted(input logic [7:0] mask, input int pos);
      rate_permitted = mask[pos];
   endfunction

   assign rate_270m_en_o = rate_permitted(rate_mask_q, RATE_270M_BIT);
   assign rate_1g5_en_o  = rate_permitted(rate_mask_q, RATE_1G5_BIT);
   assign rate_3g_en_o   = rate_permitted(rate_mask_q, RATE_3G_BIT);

   // Held while either reset bit stays set; host clears both to release
   assign cdr_reset_d = |(cdr_ctl_q & CDR_RESET_MASK);
   assign cdr_reset_o = cdr_reset_d;

   // ------------------------------------------------------------
   // Routing and automatic power down
   // ------------------------------------------------------------
   route_code_t route_code;
   logic        sel_absent;
   logic        first_drv;
   logic        second_drv;

   assign route_code = route_code_t'(route_q[1:0] & ROUTE_FIELD_MSK[1:0]);
   assign mux_sel_sec_o = route_code[1];

   always_comb begin
      first_drv  = 1'b1;
      second_drv = 1'b1;
      case (route_code)
         ROUTE_PRI_BOTH: begin
            first_drv  = 1'b1;
            second_drv = 1'b1;
         end
         ROUTE_PRI_FIRST: begin
            first_drv  = 1'b1;
            second_drv = 1'b0;
         end
         ROUTE_SEC_SECOND: begin
            first_drv  = 1'b0;
            second_drv = 1'b1;
         end
         ROUTE_SEC_BOTH: begin
            first_drv  = 1'b1;
            second_drv = 1'b1;
         end
         default: begin
            first_drv  = 1'b1;
            second_drv = 1'b1;
         end
      endcase
   end

   // Only the selected input's detector matters for power down
   assign sel_absent = mux_sel_sec_o ? absent_status[ABSENT_SEC_BIT]
                                     : absent_status[ABSENT_PRI_BIT];
   assign core_pwrdn_o       = sel_absent;
   assign cdr_pwrdn_o        = sel_absent;
   assign first_output_en_o  = first_drv && !sel_absent;
   assign second_output_en_o = second_drv && !sel_absent;

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] rd_mux;

   // Unmapped offsets and channel registers outside the bank read zero
   always_comb begin
      rd_mux = 8'h00;
      if (hit_bank) begin
         rd_mux = bank_q;
      end else if (hit_absent) begin
         rd_mux = absent_status;
      end else if (hit_cdr) begin
         rd_mux = cdr_ctl_q;
      end else if (hit_route) begin
         rd_mux = route_q;
      end else if (hit_rate) begin
         rd_mux = rate_mask_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o  <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= rd_i;
         if (rd_i) begin
            rdata_o <= rd_mux;
         end
      end
   end

endmodule // reclocker_rate_route_control

// >>> hw/rrc_pkg.sv
// Purpose: Constants shared by the reclocker rate/route control block.
// Assumes: 8-bit register addresses and data, masked register writes.
// Notes:   Offsets, field positions and reset values live here only.
package rrc_pkg;

   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 8;

   // Register offsets
   localparam logic [7:0]  OFS_BANK_SEL   = 8'hff;
   localparam logic [7:0]  OFS_SIG_ABSENT = 8'h01;
   localparam logic [7:0]  OFS_CDR_RESET  = 8'h0a;
   localparam logic [7:0]  OFS_ROUTE_SEL  = 8'h31;
   localparam logic [7:0]  OFS_RATE_MASK  = 8'ha0;

   // Bank select field
   localparam logic [7:0]  BANK_FIELD_MASK = 8'h07;
   localparam logic [7:0]  BANK_CHANNEL    = 8'h04;

   // Field positions
   localparam int          RATE_270M_BIT   = 4;
   localparam int          RATE_1G5_BIT    = 3;
   localparam int          RATE_3G_BIT     = 2;
   localparam logic [7:0]  CDR_RESET_MASK  = 8'h0c;
   localparam logic [7:0]  ROUTE_FIELD_MSK = 8'h03;
   localparam int          ABSENT_PRI_BIT  = 0;
   localparam int          ABSENT_SEC_BIT  = 1;

   // Reset values
   localparam logic [7:0]  RATE_MASK_RST   = 8'h1c;
   localparam logic [7:0]  CDR_RESET_RST   = 8'h00;
   localparam logic [7:0]  ROUTE_SEL_RST   = 8'h00;
   localparam logic [7:0]  BANK_SEL_RST    = 8'h00;

   // Routing codes
   typedef enum logic [1:0] {
      ROUTE_PRI_BOTH = 2'b00,
      ROUTE_PRI_FIRST = 2'b01,
      ROUTE_SEC_SECOND = 2'b10,
      ROUTE_SEC_BOTH = 2'b11
   } route_code_t;

endpackage
